// file: period_timer_pwm.sv
// Purpose : 8-bit period timer with pre/postscaler and a 10-bit pwm
// Assumes : clock_in is the oscillator; registers over AXI4-Lite
// Notes   : all state lives in one struct, one comb and one flop process
// Notes   : only the low byte of each 32-bit word carries a register
// Notes   : the pin goes low one clock after pulse mode is switched off
// Notes   : unmapped offsets answer with a slave error, no store
//
// Behaviour
// - timer runs from oscillator divided by four
// - prescaler divides by 1, 4 or 16
// - count wraps to zero after period match
// - postscaler divides matches by 1 to 16
// - postscaler output sets timer match flag
// - count and period writable; reset 00, ff
// - timer counts only while enable bit set
// - count or control write clears scalers
// - control write leaves count unchanged
// - period is (period+1) x4 x prescale
// - period start sets pin unless duty zero
// - period start copies duty into active register
// - duty is byte plus two control bits
// - duty applies next period; active writable only with pulse mode off
// - high time is duty x osc x prescale
// - active register plus latch double-buffer duty
// - time base extends count with two bits
// - time base equal to duty clears pin
`timescale 1ns/1ps
`include "period_timer_consts.svh"

module period_timer_pwm
    import period_timer_pkg::*;
#(
    parameter int ADDR_W = 8   // byte address width of the slave
) (
    input  wire logic              clock_in,
    input  wire logic              sys_rst_in,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    output logic [1:0]             s_axi_bresp_out,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    output logic [31:0]            s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,
    output logic                   pulse_output_pin_out,
    output logic                   irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // register map, one byte per aligned word
    //   00 control: bit0 enable, bits2:1 prescale, bits6:3 postscale
    //      prescale code 0 is 1:1, 1 is 1:4, 2 and 3 are 1:16
    //      postscale code n divides period matches by n+1
    //      any write clears both scaler counters, never the count
    //   04 count, read and write; a write clears both scalers
    //   08 period, read and write; loads all ones at reset
    //   0c duty upper eight bits, written at any time
    //   10 pulse mode enable in bit0, duty low two bits in bits5:4
    //   14 active duty; writes ignored while pulse mode runs
    //   18 status, bit0 match flag, read only
    //   1c clear, write one to bit0 drops the flag, reads zero
    //   20 interrupt enable, bit0
    //
    // timing
    //   the oscillator phase counter free-runs from reset, so the
    //   instruction clock is every fourth oscillator edge; the timer
    //   steps on phase three edges only, further divided by prescale
    //   one period is (period+1) steps, each four clocks times prescale
    //   the pin rises on the step that wraps the count, unless the new
    //   duty is zero, and falls on the edge where the 10-bit time base
    //   reaches the active duty; so the high time is duty times prescale
    //   oscillator clocks, with no extra registering cycle
    //   a duty larger than the steps in one period is never reached,
    //   so the pin then stays high over the whole period
    //
    // hazards
    //   the time base low bits change source with the prescale code, so
    //   a prescale change mid period can shorten or stretch one pulse;
    //   the control write clears the prescaler at the same time, which
    //   keeps the damage to that single period
    //   the new duty is only copied at a period start, which is what
    //   keeps a software update from cutting a pulse in half
    //   a flag set and a clear in one cycle leave the flag set, so a
    //   match is never lost to a late clear
    //
    // bus
    //   write address and data are taken in either order; the store and
    //   the response come on the edge after both are held
    //   read data are sampled from the address on the taking edge and
    //   stand until rready is seen
    //   one read at most is in flight; a second write can be taken while a response waits
    //
    ////////////////////////////////////////////////////////////////////////
    // state
    state_t s_q;            // registered state
    state_t s_d;            // next state
    logic   inst_tick;      // one oscillator clock per instruction clock
    logic   pre_tick;       // prescaler output, the increment cycle
    logic   per_match;      // count equals period on an increment
    logic   post_tick;      // postscaler output
    logic [1:0] tb_low;     // low two bits of the time base
    logic [9:0] time_base;  // 10-bit pwm time base
    logic [9:0] duty_full;  // active duty with its latch
    logic   do_write;       // register write happens this cycle
    logic [7:0] wbyte;      // low byte of write data
    logic [7:0] rd_byte;    // selected read byte
    logic   rd_hit;         // read address decodes

    ////////////////////////////////////////////////////////////////////////
    // timer, pwm and register logic
    always_comb begin
        s_d       = s_q;
        pre_tick  = 1'b0;
        per_match = 1'b0;
        post_tick = 1'b0;
        inst_tick  = (s_q.phase == `PHASE_LAST);
        s_d.phase  = s_q.phase + 2'h1;

        if (s_q.en && inst_tick) begin
            if (s_q.psel == `PS_DIV1) begin
                pre_tick = 1'b1;
            end else if ((s_q.psel == `PS_DIV4 && s_q.pre == `PRE_LAST4) ||
                         (s_q.psel != `PS_DIV4 && s_q.pre == `PRE_LAST16)) begin
                pre_tick  = 1'b1;
                s_d.pre   = 4'h0;
            end else begin
                s_d.pre = s_q.pre + 4'h1;
            end
        end

        // compare and wrap on increment cycle
        if (pre_tick) begin
            if (s_q.count == s_q.period) begin
                per_match = 1'b1;
                s_d.count = 8'h00;
            end else begin
                s_d.count = s_q.count + 8'h01;
            end
        end

        // time base low bits by prescale
        // next-state time base: the pin falls on the edge that reaches
        // the duty, not one registering cycle later
        if (s_q.psel == `PS_DIV1) begin
            tb_low = s_d.phase;
        end else if (s_q.psel == `PS_DIV4) begin
            tb_low = s_d.pre[1:0];
        end else begin
            tb_low = s_d.pre[3:2];
        end
        time_base = {s_d.count, tb_low};
        duty_full = {s_q.duty_act, s_q.duty_latch};

        // clear on duty match; an unreached duty never clears
        // pin stays high without a match
        // duty counted in time base steps
        if (s_q.pwm_en && time_base == duty_full) begin
            s_d.pin = 1'b0;
        end

        // new duty only at period start
        if (per_match && s_q.pwm_en) begin
            s_d.duty_act   = s_q.duty_lo;
            s_d.duty_latch = s_q.duty_bits;
            // set pin unless new duty is zero
            s_d.pin = ({s_q.duty_lo, s_q.duty_bits} != 10'h000);
        end
        if (!s_q.pwm_en) begin
            s_d.pin = 1'b0;  // pin idles low outside pulse mode
        end

        if (per_match) begin
            if (s_q.post == s_q.osel) begin
                post_tick = 1'b1;
                s_d.post  = 4'h0;
            end else begin
                s_d.post = s_q.post + 4'h1;
            end
        end

        ////////////////////////////////////////////////////////////////////
        // axi write channels; address and data taken in either order
        if (s_axi_awvalid_in && s_q.awready) begin
            s_d.aw_held = 1'b1;
            s_d.awready = 1'b0;
            s_d.awaddr  = 8'(s_axi_awaddr_in);
        end
        if (s_axi_wvalid_in && s_q.wready) begin
            s_d.w_held = 1'b1;
            s_d.wready = 1'b0;
            s_d.wdata  = s_axi_wdata_in[7:0];
            s_d.wstb   = s_axi_wstrb_in[0];
        end
        do_write = s_q.aw_held && s_q.w_held && !s_q.bvalid;
        wbyte    = s_q.wdata;
        if (do_write) begin
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.awready = 1'b1;
            s_d.wready  = 1'b1;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = `RESP_OKAY;
            case (s_q.awaddr)
                `OFS_CTRL: begin
                    if (s_q.wstb) begin
                        s_d.en   = wbyte[`CTRL_EN_BIT];
                        s_d.psel = wbyte[`CTRL_PS_HI:`CTRL_PS_LO];
                        s_d.osel = wbyte[`CTRL_OS_HI:`CTRL_OS_LO];
                        // count kept, any increment still lands
                        s_d.pre  = 4'h0;
                        s_d.post = 4'h0;
                    end
                end
                `OFS_COUNT: begin
                    if (s_q.wstb) begin
                        s_d.count = wbyte;
                        s_d.pre   = 4'h0;
                        s_d.post  = 4'h0;
                    end
                end
                `OFS_PERIOD: begin
                    if (s_q.wstb) begin
                        s_d.period = wbyte;
                    end
                end
                `OFS_DUTY_LO: begin
                    if (s_q.wstb) begin
                        s_d.duty_lo = wbyte;
                    end
                end
                `OFS_CCCTRL: begin
                    if (s_q.wstb) begin
                        s_d.duty_bits = wbyte[`CC_DB_HI:`CC_DB_LO];
                        s_d.pwm_en    = wbyte[`CC_PWM_BIT];
                    end
                end
                `OFS_DUTY_ACT: begin
                    if (s_q.wstb && !s_q.pwm_en) begin
                        s_d.duty_act = wbyte;
                    end
                end
                `OFS_IRQ_STAT: begin
                    // status is read-only; write ignored
                end
                `OFS_IRQ_CLR: begin
                    if (s_q.wstb && wbyte[`IRQ_MATCH_BIT]) begin
                        s_d.flag = 1'b0;
                    end
                end
                `OFS_IRQ_EN: begin
                    if (s_q.wstb) begin
                        s_d.irq_en = wbyte[`IRQ_MATCH_BIT];
                    end
                end
                default: begin
                    s_d.bresp = `RESP_SLVERR;  // unmapped address
                end
            endcase
        end
        if (s_q.bvalid && s_axi_bready_in) begin
            s_d.bvalid = 1'b0;
        end

        // postscaler output sets flag; set wins over clear
        if (post_tick) begin
            s_d.flag = 1'b1;
        end
        s_d.irq = s_d.flag && s_d.irq_en;

        ////////////////////////////////////////////////////////////////////
        // axi read channel; one read at a time
        rd_hit = 1'b1;
        case (8'(s_axi_araddr_in))
            `OFS_CTRL:     rd_byte = {1'b0, s_q.osel, s_q.psel, s_q.en};
            `OFS_COUNT:    rd_byte = s_q.count;
            `OFS_PERIOD:   rd_byte = s_q.period;
            `OFS_DUTY_LO:  rd_byte = s_q.duty_lo;
            `OFS_CCCTRL:   rd_byte = {2'h0, s_q.duty_bits, 3'h0, s_q.pwm_en};
            `OFS_DUTY_ACT: rd_byte = s_q.duty_act;
            `OFS_IRQ_STAT: rd_byte = {7'h00, s_q.flag};
            `OFS_IRQ_CLR:  rd_byte = 8'h00;  // write-only, reads zero
            `OFS_IRQ_EN:   rd_byte = {7'h00, s_q.irq_en};
            default: begin
                rd_byte = 8'h00;
                rd_hit  = 1'b0;
            end
        endcase
        if (s_axi_arvalid_in && s_q.arready) begin
            s_d.arready = 1'b0;
            s_d.rvalid  = 1'b1;
            s_d.rdata   = {24'h000000, rd_byte};
            s_d.rresp   = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (s_q.rvalid && s_axi_rready_in) begin
            s_d.rvalid  = 1'b0;
            s_d.arready = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; reset clears scalers and loads count and period
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_q         <= '0;
            s_q.count   <= `RST_COUNT;
            s_q.period  <= `RST_PERIOD;
            s_q.awready <= 1'b1;
            s_q.wready  <= 1'b1;
            s_q.arready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign s_axi_awready_out    = s_q.awready;
    assign s_axi_wready_out     = s_q.wready;
    assign s_axi_bvalid_out     = s_q.bvalid;
    assign s_axi_bresp_out      = s_q.bresp;
    assign s_axi_arready_out    = s_q.arready;
    assign s_axi_rvalid_out     = s_q.rvalid;
    assign s_axi_rdata_out      = s_q.rdata;
    assign s_axi_rresp_out      = s_q.rresp;
    assign pulse_output_pin_out = s_q.pin;
    assign irq_out              = s_q.irq;

endmodule : period_timer_pwm

// file: period_timer_consts.svh
// Purpose : register offsets, field positions, reset values and counts
// Assumes : 32-bit AXI4-Lite data, one aligned word per register
// Notes   : included by the timer module and the bench
`ifndef PERIOD_TIMER_CONSTS_SVH
`define PERIOD_TIMER_CONSTS_SVH

// register byte offsets
`define OFS_CTRL      8'h00
`define OFS_COUNT     8'h04
`define OFS_PERIOD    8'h08
`define OFS_DUTY_LO   8'h0c
`define OFS_CCCTRL    8'h10
`define OFS_DUTY_ACT  8'h14
`define OFS_IRQ_STAT  8'h18
`define OFS_IRQ_CLR   8'h1c
`define OFS_IRQ_EN    8'h20

// timer_control fields
`define CTRL_EN_BIT   0
`define CTRL_PS_LO    1
`define CTRL_PS_HI    2
`define CTRL_OS_LO    3
`define CTRL_OS_HI    6

// capture_compare_control fields
`define CC_PWM_BIT    0
`define CC_DB_LO      4
`define CC_DB_HI      5

// interrupt bit of the flag register
`define IRQ_MATCH_BIT 0

// reset values
`define RST_COUNT     8'h00
`define RST_PERIOD    8'hff

// prescale select codes and prescaler terminal counts
`define PS_DIV1       2'h0
`define PS_DIV4       2'h1
`define PRE_LAST4     4'h3
`define PRE_LAST16    4'hf

// instruction clock is four oscillator clocks
`define PHASE_LAST    2'h3

// axi responses
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// file: period_timer_pkg.sv
// Purpose : types shared by the period timer and its bench
// Assumes : constants come from period_timer_consts.svh
// Notes   : whole module state is one packed struct
package period_timer_pkg;

    // whole state of the timer, pwm and bus slave
    typedef struct packed {
        logic [1:0]  phase;      // oscillator phase within instruction clock
        logic [3:0]  pre;        // prescaler counter
        logic [3:0]  post;       // postscaler counter
        logic        en;         // timer_enable_bit
        logic [1:0]  psel;       // prescale_select
        logic [3:0]  osel;       // postscale_select
        logic [7:0]  count;      // timer_count
        logic [7:0]  period;     // timer_period
        logic [7:0]  duty_lo;    // duty_low_byte
        logic [1:0]  duty_bits;  // duty_low_bits
        logic        pwm_en;     // pulse mode active
        logic [7:0]  duty_act;   // duty_active
        logic [1:0]  duty_latch; // hidden two-bit latch
        logic        pin;        // pulse_output_pin
        logic        flag;       // timer_match_flag
        logic        irq_en;     // interrupt enable
        logic        irq;        // interrupt output
        logic        awready;
        logic        aw_held;
        logic [7:0]  awaddr;
        logic        wready;
        logic        w_held;
        logic [7:0]  wdata;
        logic        wstb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } state_t;

endpackage : period_timer_pkg

// file: period_timer_pwm_assertions.sv
// Purpose : bus and pulse pin checks for period_timer_pwm
// Assumes : single clock, async active-high reset
// Notes   : phase copy restarts with reset, like the timer's own
`timescale 1ns/1ps
module period_timer_checks
    import period_timer_pkg::*;
(
    input wire logic        clock_in,
    input wire logic        sys_rst_in,
    input wire logic        s_axi_awvalid_in,
    input wire logic        s_axi_awready_out,
    input wire logic        s_axi_wvalid_in,
    input wire logic        s_axi_wready_out,
    input wire logic        s_axi_bvalid_out,
    input wire logic        s_axi_bready_in,
    input wire logic [1:0]  s_axi_bresp_out,
    input wire logic        s_axi_arvalid_in,
    input wire logic        s_axi_arready_out,
    input wire logic        s_axi_rvalid_out,
    input wire logic        s_axi_rready_in,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic        pulse_output_pin_out,
    input wire logic        irq_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    logic [1:0] ph_q; // oscillator phase copy
    // free-running divide by four
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) ph_q <= 2'h0;
        else ph_q <= ph_q + 2'h1;
    end
    sequence wr_taken;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence rd_taken;
        s_axi_arvalid_in && s_axi_arready_out;
    endsequence
    AST_WR_ANSWER: assert property (wr_taken |=> !s_axi_awready_out ##1 s_axi_bvalid_out)
        else $error("write answer late");
    AST_B_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
        else $error("bvalid dropped");
    AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid_out && !s_axi_arready_out)
        else $error("read answer late");
    AST_R_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> $stable(s_axi_rdata_out))
        else $error("rdata changed");
    AST_RDATA_HI: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
        else $error("rdata upper bits set");
    AST_BRESP: assert property (s_axi_bvalid_out |-> s_axi_bresp_out inside {2'h0, 2'h2})
        else $error("bresp code");
    AST_PIN_PHASE: assert property ($rose(pulse_output_pin_out) |-> ph_q == 2'h0)
        else $error("pin set off the instruction clock");
    AST_IRQ_FALL: assert property ($fell(irq_out) |-> s_axi_bvalid_out)
        else $error("irq dropped without a write");
endmodule : period_timer_checks
bind period_timer_pwm period_timer_checks u_chk (.*);

// file: pulse_load_model.sv
// Purpose : load on the pulse pin, measures period and high time
// Assumes : pin changes on clock edges only
// Notes   : figures hold the last complete measurement
`timescale 1ns/1ps
module pulse_load_model (
    input  wire logic   clock_in,
    input  wire logic   pin_in,
    output logic [15:0] period_out,
    output logic [15:0] high_out
);
    logic        pin_q = 1'b0;  // last pin level
    logic [15:0] per_q = 16'h0; // edges since last rise
    always @(posedge clock_in) begin
        pin_q <= pin_in;
        per_q <= (pin_in && !pin_q) ? 16'h1 : per_q + 16'h1;
        if (pin_in && !pin_q) period_out <= per_q;
        if (!pin_in && pin_q) high_out <= per_q;
    end
endmodule : pulse_load_model

// file: tb_top.sv
// Purpose : register, pwm and interrupt tests of period_timer_pwm
// Assumes : 25 MHz clock, AXI4-Lite master tasks
// Notes   : figures derived from period 3 and duty 6
`timescale 1ns/1ps
`include "period_timer_consts.svh"
module tb_top
    import period_timer_pkg::*;
;
    logic        clock_in, sys_rst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
    logic        s_axi_arvalid_in, s_axi_rready_in;
    logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
    logic [3:0]  s_axi_wstrb_in;
    logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic        s_axi_rvalid_out, pulse_output_pin_out, irq_out;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out;
    logic [15:0] per, hi;
    int          n_fail = 0;
    int          total_checks = 0;
    int          k;
    period_timer_pwm DUT (.*);
    pulse_load_model u_load (.clock_in(clock_in), .pin_in(pulse_output_pin_out),
                             .period_out(per), .high_out(hi));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic finish_test;
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    // bounded wait ran out
    task automatic tmo;
        n_fail++;
        $display("[FAIL] wait exp done got timeout");
        finish_test();
    endtask : tmo
    // one write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
        int i;
        @(posedge clock_in);
        s_axi_awaddr_in <= a;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wdata_in <= {24'h0, d};
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge clock_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
            if (s_axi_bvalid_out) break;
        end
        if (i == 100) tmo();
        s_axi_bready_in <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp_out});
    endtask : wr
    // one read, data compared on the handshake edge
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = 2'h0);
        int i;
        @(posedge clock_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge clock_in);
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
            if (s_axi_rvalid_out) break;
        end
        if (i == 100) tmo();
        s_axi_rready_in <= 1'b0;
        chk($sformatf("reg %h", a), {24'h0, e}, s_axi_rdata_out);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp_out});
    endtask : rd
    // count high cycles of the pin over a window
    task automatic hcount(input int n, input int e);
        int c;
        c = 0;
        repeat (n) begin
            @(posedge clock_in);
            if (pulse_output_pin_out === 1'b1) c++;
        end
        chk("high cycles", e, c);
    endtask : hcount
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    initial begin
        {sys_rst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 4'h8;
        {s_axi_arvalid_in, s_axi_rready_in, s_axi_awaddr_in, s_axi_araddr_in} = 18'h0;
        s_axi_wdata_in = 32'h0;
        s_axi_wstrb_in = 4'h1;
        repeat (3) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        rd(`OFS_COUNT, `RST_COUNT);
        rd(`OFS_PERIOD, `RST_PERIOD);
        rd(8'h24, 8'h00, `RESP_SLVERR);
        wr(8'h24, 8'h11, `RESP_SLVERR);
        wr(`OFS_PERIOD, 8'h3c);
        rd(`OFS_PERIOD, 8'h3c);
        wr(`OFS_COUNT, 8'h05);
        wr(`OFS_CTRL, 8'h04);
        rd(`OFS_COUNT, 8'h05);
        repeat (20) @(posedge clock_in);
        rd(`OFS_COUNT, 8'h05);
        $display("test registers done");
        wr(`OFS_PERIOD, 8'h03);
        wr(`OFS_COUNT, 8'h00);
        wr(`OFS_DUTY_LO, 8'h01);
        wr(`OFS_CCCTRL, 8'h21);
        // prescale codes 0 to 2: period 16, duty 6 steps
        for (k = 0; k < 3; k++) begin
            wr(`OFS_CTRL, 8'(2 * k + 1));
            repeat (80 << (2 * k)) @(posedge clock_in);
            chk("period", 16 << (2 * k), {16'h0, per});
            chk("high", 6 << (2 * k), {16'h0, hi});
        end
        rd(`OFS_DUTY_ACT, 8'h01);
        wr(`OFS_DUTY_ACT, 8'h55);
        rd(`OFS_DUTY_ACT, 8'h01);
        wr(`OFS_CTRL, 8'h01);
        wr(`OFS_DUTY_LO, 8'h00);
        wr(`OFS_CCCTRL, 8'h01);
        repeat (40) @(posedge clock_in);
        hcount(40, 0);
        wr(`OFS_DUTY_LO, 8'hff);
        repeat (40) @(posedge clock_in);
        hcount(40, 40);
        $display("test pwm done");
        wr(`OFS_CTRL, 8'h00);
        wr(`OFS_COUNT, 8'h00);
        wr(`OFS_IRQ_EN, 8'h01);
        wr(`OFS_IRQ_CLR, 8'h01);
        wr(`OFS_CTRL, 8'h11);
        for (k = 0; k < 200 && irq_out !== 1'b1; k++) @(posedge clock_in);
        if (k == 200) tmo();
        chk("irq delay in window", 1, (k >= 40 && k <= 56));
        rd(`OFS_IRQ_STAT, 8'h01);
        wr(`OFS_IRQ_EN, 8'h00);
        repeat (2) @(posedge clock_in);
        chk("irq masked", 0, {31'h0, irq_out});
        wr(`OFS_CTRL, 8'h00);
        wr(`OFS_IRQ_EN, 8'h01);
        repeat (2) @(posedge clock_in);
        chk("irq enabled", 1, {31'h0, irq_out});
        wr(`OFS_IRQ_CLR, 8'h01);
        repeat (2) @(posedge clock_in);
        chk("irq cleared", 0, {31'h0, irq_out});
        rd(`OFS_IRQ_STAT, 8'h00);
        $display("test interrupt done");
        finish_test();
    end
endmodule : tb_top
